//--- design/cpu_interrupt_dispatch.sv
// Interrupt dispatch of an 8-bit core: flags, enables, vectoring and return.
// Assumes an APB master on pclk, a core that follows pc_load and flush_nop,
// and an external interrupt pin that is asynchronous to pclk.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reset leaves every interrupt disabled.
// - Vectoring needs global and source enables.
// - Peripheral sources also need group enable.
// - Flags set whatever the enables are.
// - Entry flushes, clears global, pushes, vectors.
// - Global clear: flag sets, no vectoring.
// - Pending event serviced once global sets.
// - Return pops address and sets global enable.
// - Synchronous event reaches vector in three cycles.
// - Pin event reaches vector in three-four cycles.
// - Latency ignores current instruction length.
// - Pin flag sampled for dispatch at Q1.
// - Pin flag may set in any phase, Q1 through Q4.
// - Eight-entry thirteen-bit circular return stack.
module cpu_interrupt_dispatch
  import irq_dispatch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin,
  input wire logic timer_event,
  input wire logic port_change_event,
  input wire logic [PERIPH_A_N-1:0] periph_event_a,
  input wire logic [PERIPH_B_N-1:0] periph_event_b,
  input wire logic [PC_W-1:0] pc_current,
  input wire logic return_from_irq,
  output logic [1:0] q_phase,
  output logic flush_nop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_load_value,
  output logic vector_exec,
  output logic irq_out
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  ret_stack_if stk_bus ();

  logic [1:0] q_reg;
  logic at_q1;
  logic ext_meta_reg;
  logic ext_sync_reg;
  logic ext_prev_reg;
  logic ext_edge;
  logic [7:0] irq_control_reg;
  logic [7:0] irq_control_next;
  logic [PERIPH_A_N-1:0] periph_flag_reg_a;
  logic [PERIPH_B_N-1:0] periph_flag_reg_b;
  logic [PERIPH_A_N-1:0] periph_enable_reg_a;
  logic [PERIPH_B_N-1:0] periph_enable_reg_b;
  logic [CORE_SRC_N-1:0] core_events;
  logic [CORE_SRC_N-1:0] core_clear;
  logic [CORE_SRC_N-1:0] core_flags;
  logic [CORE_SRC_N-1:0] core_enables;
  logic global_irq_enable;
  logic periph_irq_enable;
  logic [PERIPH_A_N-1:0] periph_terms_a;
  logic [PERIPH_B_N-1:0] periph_terms_b;
  logic pending;
  logic pending_reg;
  dispatch_state_t state_reg;
  logic enter_irq;
  logic take_return;
  logic bus_access;
  logic wr_fire;
  logic addr_hit;
  logic [31:0] rd_data;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic flush_nop_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_load_value_reg;
  logic vector_exec_reg;
  logic irq_out_reg;

  // ==========================================================================
  // Instruction cycle phases
  // ==========================================================================
  // Four clocks make one instruction cycle; phase zero is Q1.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_reg <= Q1_PHASE;
    else
      q_reg <= q_reg + Q_PHASE_STEP;
  end

  assign at_q1 = (q_reg == Q1_PHASE);

  // ==========================================================================
  // External pin synchroniser
  // ==========================================================================
  // Two flops guard against metastability; only the second feeds the edge detector.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_irq_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  // A rising edge may arrive in any phase, so the pin flag can set at any clock.
  assign ext_edge = ext_sync_reg & ~ext_prev_reg;

  // ==========================================================================
  // APB slave
  // ==========================================================================
  // Every access takes two access-phase cycles: pready rises one clock after
  // penable, and the write happens at the edge that sees pready high; read data is registered at the edge that raises it.
  assign bus_access = psel & penable;
  assign wr_fire = bus_access & pwrite & pready_reg & addr_hit;

  // Read mux and address decode.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr)
      OFF_IRQ_CONTROL: rd_data[7:0] = irq_control_reg;
      OFF_PERIPH_FLAG_A: rd_data[PERIPH_A_N-1:0] = periph_flag_reg_a;
      OFF_PERIPH_FLAG_B: rd_data[PERIPH_B_N-1:0] = periph_flag_reg_b;
      OFF_PERIPH_ENABLE_A: rd_data[PERIPH_A_N-1:0] = periph_enable_reg_a;
      OFF_PERIPH_ENABLE_B: rd_data[PERIPH_B_N-1:0] = periph_enable_reg_b;
      OFF_DISPATCH_STATUS:
      begin
        rd_data[STS_STATE_LSB +: 2] = state_reg;
        rd_data[STS_PENDING_BIT] = pending_reg;
        rd_data[STS_GLB_BIT] = global_irq_enable;
      end
      default: addr_hit = 1'b0;
    endcase
  end

  // Bus answer registers; an unmapped address answers with pslverr.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= bus_access & ~pready_reg;
      prdata_reg <= (bus_access & ~pready_reg & ~pwrite) ? rd_data : 32'h0000_0000;
      pslverr_reg <= bus_access & ~pready_reg & ~addr_hit;
    end
  end

  // ==========================================================================
  // Core-group flags and enables
  // ==========================================================================
  assign core_events = {timer_event, ext_edge, port_change_event};
  assign core_flags = irq_control_reg[CTL_IF_LSB +: CORE_SRC_N];
  assign core_enables = irq_control_reg[CTL_IE_LSB +: CORE_SRC_N];
  assign global_irq_enable = irq_control_reg[CTL_GLB_BIT];
  assign periph_irq_enable = irq_control_reg[CTL_GRP_BIT];
  assign core_clear = (wr_fire && paddr == OFF_IRQ_CONTROL) ?
                      pwdata[CTL_IF_LSB +: CORE_SRC_N] : '0;

  // Flags are write-one-to-clear and a same-cycle event wins over the clear.
  // The global enable is cleared on entry with priority over software, so an
  // entry can never be undone by a racing write; a return sets it again.
  always_comb
  begin
    irq_control_next = irq_control_reg;
    if (wr_fire && paddr == OFF_IRQ_CONTROL)
    begin
      irq_control_next[CTL_GLB_BIT] = pwdata[CTL_GLB_BIT];
      irq_control_next[CTL_GRP_BIT] = pwdata[CTL_GRP_BIT];
      irq_control_next[CTL_IE_LSB +: CORE_SRC_N] = pwdata[CTL_IE_LSB +: CORE_SRC_N];
    end
    irq_control_next[CTL_IF_LSB +: CORE_SRC_N] = (core_flags & ~core_clear) | core_events;
    if (take_return)
      irq_control_next[CTL_GLB_BIT] = 1'b1;
    if (enter_irq)
      irq_control_next[CTL_GLB_BIT] = 1'b0;
  end

  // Reset clears every enable, including global.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_control_reg <= CONTROL_RESET;
    else
      irq_control_reg <= irq_control_next;
  end

  // ==========================================================================
  // Peripheral-group flags and enables
  // ==========================================================================
  // Flags record their events whatever the enables say; set beats clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_flag_reg_a <= PERIPH_A_RESET;
      periph_flag_reg_b <= PERIPH_B_RESET;
    end
    else
    begin
      periph_flag_reg_a <= (periph_flag_reg_a &
        ~((wr_fire && paddr == OFF_PERIPH_FLAG_A) ? pwdata[PERIPH_A_N-1:0] : '0))
        | periph_event_a;
      periph_flag_reg_b <= (periph_flag_reg_b &
        ~((wr_fire && paddr == OFF_PERIPH_FLAG_B) ? pwdata[PERIPH_B_N-1:0] : '0))
        | periph_event_b;
    end
  end

  // Individual peripheral enables are plain read-write bits.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      periph_enable_reg_a <= PERIPH_A_RESET;
      periph_enable_reg_b <= PERIPH_B_RESET;
    end
    else
    begin
      if (wr_fire && paddr == OFF_PERIPH_ENABLE_A)
        periph_enable_reg_a <= pwdata[PERIPH_A_N-1:0];
      if (wr_fire && paddr == OFF_PERIPH_ENABLE_B)
        periph_enable_reg_b <= pwdata[PERIPH_B_N-1:0];
    end
  end

  // ==========================================================================
  // Request formation
  // ==========================================================================
  // Each flag is gated by its own enable; the peripheral terms also by the
  // group enable. Global enable is applied only where dispatch is decided.
  assign periph_terms_a = periph_flag_reg_a & periph_enable_reg_a;
  assign periph_terms_b = periph_flag_reg_b & periph_enable_reg_b;
  assign pending = (|(core_flags & core_enables))
                   | (periph_irq_enable & (|periph_terms_a | |periph_terms_b));

  // Registered so that the interrupt line and the dispatch see one value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_reg <= 1'b0;
      irq_out_reg <= 1'b0;
    end
    else
    begin
      pending_reg <= pending;
      irq_out_reg <= pending;
    end
  end

  // ==========================================================================
  // Dispatch sequence
  // ==========================================================================
  // The request is looked at only at Q1, once per instruction cycle, so an
  // asynchronous pin edge waits up to one more cycle than a synchronous event.
  // Nothing here looks at the running instruction, so a two-cycle instruction
  // gives the same latency as a one-cycle one.
  assign enter_irq = at_q1 && state_reg == ST_IDLE
                     && pending_reg && global_irq_enable;
  assign take_return = return_from_irq && state_reg == ST_IDLE && !enter_irq;

  // Each step lasts one instruction cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= ST_IDLE;
    else if (at_q1)
    begin
      unique case (state_reg)
        ST_IDLE: if (enter_irq) state_reg <= ST_FLUSH;
        ST_FLUSH: state_reg <= ST_FETCH;
        ST_FETCH: state_reg <= ST_EXEC;
        ST_EXEC: state_reg <= ST_IDLE;
      endcase
    end
  end

  // The prefetched instruction is replaced by a no-operation for the whole
  // flush cycle so that it changes no register or flag.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flush_nop_reg <= 1'b0;
    else if (at_q1)
      flush_nop_reg <= enter_irq;
  end

  // Program counter loads: the vector during entry, the popped address on return.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_load_reg <= 1'b0;
      pc_load_value_reg <= PC_RESET;
    end
    else if (at_q1 && state_reg == ST_FLUSH)
    begin
      pc_load_reg <= 1'b1;
      pc_load_value_reg <= IRQ_VECTOR_ADDR;
    end
    else if (take_return)
    begin
      pc_load_reg <= 1'b1;
      pc_load_value_reg <= stk_bus.top_addr;
    end
    else
      pc_load_reg <= 1'b0;
  end

  // Marks the first clock of execution at the vector address.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      vector_exec_reg <= 1'b0;
    else
      vector_exec_reg <= at_q1 && state_reg == ST_FETCH;
  end

  // ==========================================================================
  // Return stack
  // ==========================================================================
  // The current program counter is saved in the same clock as entry.
  assign stk_bus.push = enter_irq;
  assign stk_bus.push_addr = pc_current;
  assign stk_bus.pop = take_return;

  ret_addr_stack ret_addr_stack_inst
  (
    .pclk(pclk),
    .presetn(presetn),
    .stk(stk_bus.store)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign q_phase = q_reg;
  assign flush_nop = flush_nop_reg;
  assign pc_load = pc_load_reg;
  assign pc_load_value = pc_load_value_reg;
  assign vector_exec = vector_exec_reg;
  assign irq_out = irq_out_reg;

endmodule
`default_nettype wire

//--- common/irq_dispatch_pkg.sv
// Constants, register map and state encoding of the interrupt dispatch block.
// Assumes one clock (pclk, 125 MHz) and four clock phases per instruction cycle.
package irq_dispatch_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned Q_PHASES_PER_INSTR = 4;
  localparam int unsigned INSTR_CYCLE_TIME_NS = CLK_PERIOD_NS * Q_PHASES_PER_INSTR;
  localparam int unsigned LATENCY_INSTR = 3;
  localparam logic [1:0] Q1_PHASE = 2'h0;
  localparam logic [1:0] Q_PHASE_STEP = 2'h1;

  // ==========================================================================
  // Program counter and return stack
  // ==========================================================================
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned STACK_PTR_W = 3;
  localparam logic [STACK_PTR_W-1:0] STACK_PTR_STEP = 3'h1;
  localparam logic [STACK_PTR_W-1:0] STACK_PTR_RESET = 3'h0;
  localparam logic [PC_W-1:0] IRQ_VECTOR_ADDR = 13'h0004;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  // ==========================================================================
  // Register map (byte addresses) and reset values
  // ==========================================================================
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_FLAG_A = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_FLAG_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_ENABLE_A = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PERIPH_ENABLE_B = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DISPATCH_STATUS = 8'h14;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_A_RESET = 8'h00;
  localparam logic [0:0] PERIPH_B_RESET = 1'h0;

  // Control register fields: global enable, group enable, three core enables, three flags.
  localparam int unsigned CTL_GLB_BIT = 7;
  localparam int unsigned CTL_GRP_BIT = 6;
  localparam int unsigned CTL_IE_LSB = 3;
  localparam int unsigned CTL_IF_LSB = 0;
  localparam int unsigned CORE_SRC_N = 3;
  localparam int unsigned PERIPH_A_N = 8;
  localparam int unsigned PERIPH_B_N = 1;

  // Dispatch status fields.
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_PENDING_BIT = 2;
  localparam int unsigned STS_GLB_BIT = 3;

  // Dispatch sequence, Gray coded along its only path.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_FLUSH = 2'h1,
    ST_FETCH = 2'h3,
    ST_EXEC = 2'h2
  } dispatch_state_t;

endpackage

//--- common/ret_stack_if.sv
// Link between the dispatch logic and its return-address stack.
// Assumes both ends run on the same clock; push and pop are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
interface ret_stack_if;
  import irq_dispatch_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_addr;
  modport owner
  (
    output push,
    output pop,
    output push_addr,
    input top_addr
  );
  modport store
  (
    input push,
    input pop,
    input push_addr,
    output top_addr
  );
endinterface
`default_nettype wire

//--- design/ret_addr_stack.sv
// Eight-entry circular return-address stack.
// Assumes push and pop are never asserted together; push wins if they are.
`timescale 1ns/1ps
`default_nettype none
module ret_addr_stack
  import irq_dispatch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  ret_stack_if.store stk
);

  logic [PC_W-1:0] mem [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr_reg;
  logic [STACK_PTR_W-1:0] below_ptr;

  // ==========================================================================
  // Pointer
  // ==========================================================================
  // The pointer wraps freely, so a ninth push silently overwrites the oldest.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ptr_reg <= STACK_PTR_RESET;
    else if (stk.push)
      ptr_reg <= ptr_reg + STACK_PTR_STEP;
    else if (stk.pop)
      ptr_reg <= below_ptr;
  end

  // Storage is not reset; an underflowing pop returns whatever stands there.
  always_ff @(posedge pclk)
  begin
    if (stk.push)
      mem[ptr_reg] <= stk.push_addr;
  end

  // The top entry sits just below the pointer.
  assign below_ptr = ptr_reg - STACK_PTR_STEP;
  assign stk.top_addr = mem[below_ptr];

endmodule
`default_nettype wire

//--- bench/cpu_interrupt_dispatch_props.sv
// Checker for the dispatch block, watching only its top-level ports.
// Assumes one clock pclk and the active-low asynchronous reset presetn.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_dispatch_props
  import irq_dispatch_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic return_from_irq,
  input wire logic [1:0] q_phase,
  input wire logic flush_nop,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_load_value,
  input wire logic vector_exec,
  input wire logic irq_out
);
  // ==========
  // Dispatch timing
  // ==========
  // One domain, so the clock and the reset are given once for every check.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Entry is counted from the rise of flush_nop, one edge after the entry edge.
  flush_len_a: assert property ($rose(flush_nop) |-> flush_nop[*4] ##1 !flush_nop)
    else $error("flush window is not one instruction cycle");
  vec_load_a: assert property ($rose(flush_nop) |-> ##4 pc_load && pc_load_value == IRQ_VECTOR_ADDR)
    else $error("vector address not loaded at the next instruction cycle");
  vec_exec_a: assert property ($rose(flush_nop) |-> ##8 vector_exec)
    else $error("vector execution late or early");
  entry_q1_a: assert property ($rose(flush_nop) |-> q_phase == Q_PHASE_STEP)
    else $error("entry not taken on the first phase");
  entry_cause_a: assert property ($rose(flush_nop) |-> $past(irq_out))
    else $error("entry without a pending request");
  load_cause_a: assert property (pc_load |-> $past(return_from_irq) || $past(flush_nop))
    else $error("program counter loaded without cause");
  exec_order_a: assert property (vector_exec |-> $past(pc_load, 4))
    else $error("vector execution not four clocks after the load");
  phase_wrap_a: assert property (q_phase == 2'h3 |=> q_phase == Q1_PHASE)
    else $error("instruction cycle is not four phases");
  // Right after reset nothing may be requested or dispatched.
  reset_quiet_a: assert property ($rose(presetn) |-> !irq_out && !flush_nop && !pc_load)
    else $error("activity right after reset");
endmodule

bind cpu_interrupt_dispatch cpu_interrupt_dispatch_props props_inst (.pclk, .presetn,
  .return_from_irq, .q_phase, .flush_nop, .pc_load, .pc_load_value, .vector_exec, .irq_out);
`default_nettype wire

//--- bench/event_source_model.sv
// Model of the peripheral event sources and the external interrupt pin.
// Assumes every task is entered just after a rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module event_source_model
  import irq_dispatch_pkg::*;
(
  input wire logic pclk,
  output logic ext_irq_pin,
  output logic timer_event,
  output logic port_change_event,
  output logic [PERIPH_A_N-1:0] periph_event_a,
  output logic [PERIPH_B_N-1:0] periph_event_b
);
  // ==========
  // Sources
  // ==========
  // All sources start quiet, so no flag is set before software looks.
  initial
  begin
    ext_irq_pin = 1'b0;
    timer_event = 1'b0;
    port_change_event = 1'b0;
    periph_event_a = '0;
    periph_event_b = '0;
  end

  // Synchronous sources give one-cycle pulses; peripherals pulse by mask.
  task fire(input logic t, input logic p, input logic [PERIPH_A_N-1:0] a,
    input logic [PERIPH_B_N-1:0] b);
    timer_event <= t;
    port_change_event <= p;
    periph_event_a <= a;
    periph_event_b <= b;
    @(posedge pclk);
    timer_event <= 1'b0;
    port_change_event <= 1'b0;
    periph_event_a <= '0;
    periph_event_b <= '0;
  endtask

  // The pin is a level; only its rising edge matters to the block.
  task pin(input logic lvl);
    ext_irq_pin <= lvl;
  endtask
endmodule
`default_nettype wire

//--- bench/cpu_interrupt_dispatch_test.sv
// Self-checking bench for the interrupt dispatch block.
// Assumes the event source model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module cpu_interrupt_dispatch_test
  import irq_dispatch_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic ext_irq_pin, timer_event, port_change_event, return_from_irq;
  logic [PERIPH_A_N-1:0] periph_event_a;
  logic [PERIPH_B_N-1:0] periph_event_b;
  logic [PC_W-1:0] pc_current, pc_load_value;
  logic [1:0] q_phase;
  logic flush_nop, pc_load, vector_exec, irq_out;
  int err_total, tests_run, cyc, k;

  cpu_interrupt_dispatch cpu_interrupt_dispatch_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin, .timer_event,
    .port_change_event, .periph_event_a, .periph_event_b, .pc_current, .return_from_irq,
    .q_phase, .flush_nop, .pc_load, .pc_load_value, .vector_exec, .irq_out);
  event_source_model event_source_model_inst (.pclk, .ext_irq_pin, .timer_event,
    .port_change_event, .periph_event_a, .periph_event_b);

  // ==========
  // Clock, timeout and verdict
  // ==========
  // Free-running 125 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  end

  // A hang ends the run as a failure instead of stalling the simulator.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      close_out;
    end
  end

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", n, exp, seen);
      err_total++;
    end
  endtask

  // ==========
  // Bus and core helpers
  // ==========
  // One APB transfer; an idle edge follows so the next setup never collides.
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, rdata, exp);
  endtask

  // Stops at an edge whose sampled phase is ph.
  task align(input logic [1:0] ph);
    do @(posedge pclk); while (q_phase !== ph);
  endtask

  // Counts edges until vector execution is seen, checking the load on the way.
  task wait_vec;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
      if (pc_load === 1'b1)
        chk("vector", {19'h0, pc_load_value}, {19'h0, IRQ_VECTOR_ADDR});
    end
    while (vector_exec !== 1'b1);
  endtask

  task ret(input logic [PC_W-1:0] exp);
    return_from_irq <= 1'b1;
    @(posedge pclk);
    return_from_irq <= 1'b0;
    @(posedge pclk);
    chk("return load", {18'h0, pc_load, pc_load_value}, {18'h0, 1'b1, exp});
  endtask

  // ==========
  // Scenarios
  // ==========
  task t_reset;
    rd(OFF_IRQ_CONTROL, 32'h0, "control");
    rd(OFF_PERIPH_ENABLE_A, 32'h0, "enable a");
    rd(OFF_PERIPH_ENABLE_B, 32'h0, "enable b");
    rd(OFF_DISPATCH_STATUS, 32'h0, "status");
    rd(8'h18, 32'h0, "unmapped");
    chk("unmapped error", {31'h0, rerr}, 32'h1);
  endtask

  // Each core source, peripheral B and four of the eight peripheral A sources fire with all enables off: flags only, no request.
  task t_flags;
    event_source_model_inst.pin(1'b1);
    event_source_model_inst.fire(1'b1, 1'b1, 8'ha5, 1'b1);
    repeat (4) @(posedge pclk);
    chk("quiet irq", {31'h0, irq_out}, 32'h0);
    rd(OFF_IRQ_CONTROL, 32'h7, "core flags");
    rd(OFF_PERIPH_FLAG_A, 32'ha5, "flags a");
    rd(OFF_PERIPH_FLAG_B, 32'h1, "flag b");
    rd(OFF_DISPATCH_STATUS, 32'h0, "no entry");
    wr(OFF_IRQ_CONTROL, 32'h7);
    wr(OFF_PERIPH_FLAG_A, 32'hff);
    wr(OFF_PERIPH_FLAG_B, 32'h1);
    rd(OFF_IRQ_CONTROL, 32'h0, "core cleared");
    rd(OFF_PERIPH_FLAG_A, 32'h0, "a cleared");
    rd(OFF_PERIPH_FLAG_B, 32'h0, "b cleared");
    event_source_model_inst.pin(1'b0);
  endtask

  // A peripheral flag waits for the group enable, then for global enable.
  task t_group;
    pc_current <= 13'h1abc;
    wr(OFF_PERIPH_ENABLE_A, 32'h1);
    event_source_model_inst.fire(1'b0, 1'b0, 8'h01, 1'b0);
    repeat (3) @(posedge pclk);
    chk("group off", {31'h0, irq_out}, 32'h0);
    wr(OFF_IRQ_CONTROL, 32'h40);
    repeat (3) @(posedge pclk);
    chk("group on", {31'h0, irq_out}, 32'h1);
    wr(OFF_IRQ_CONTROL, 32'hc0);
    wait_vec;
    rd(OFF_IRQ_CONTROL, 32'h40, "entry clears global");
    wr(OFF_PERIPH_FLAG_A, 32'h1);
    ret(13'h1abc);
    rd(OFF_IRQ_CONTROL, 32'hc0, "return sets global");
    wr(OFF_IRQ_CONTROL, 32'h0);
  endtask

  // Nine nested entries wrap the stack; pops give the newest eight, then the ninth.
  task t_stack;
    for (int i = 1; i <= 9; i++)
    begin
      wr(OFF_IRQ_CONTROL, 32'ha0);
      pc_current <= 13'(i);
      align(2'h3);
      event_source_model_inst.fire(1'b1, 1'b0, 8'h0, 1'b0);
      wait_vec;
      chk("sync latency", k, LATENCY_INSTR * Q_PHASES_PER_INSTR + 1);
      wr(OFF_IRQ_CONTROL, 32'h24);
    end
    for (int i = 0; i < 9; i++)
      ret((i == 8) ? 13'h9 : 13'(9 - i));
    rd(OFF_IRQ_CONTROL, 32'ha0, "global back");
    wr(OFF_IRQ_CONTROL, 32'h0);
  endtask

  // The pin rises in each of the four phases; latency stays within 3 to 4 cycles.
  task t_pin;
    pc_current <= 13'h0777;
    wr(OFF_IRQ_CONTROL, 32'h90);
    for (int ph = 0; ph < 4; ph++)
    begin
      align(2'(ph));
      event_source_model_inst.pin(1'b1);
      wait_vec;
      chk("pin latency", {31'h0, k >= 13 && k <= 17}, 32'h1);
      wr(OFF_IRQ_CONTROL, 32'h12);
      event_source_model_inst.pin(1'b0);
      ret(13'h0777);
    end
    wr(OFF_IRQ_CONTROL, 32'h0);
  endtask

  // A reset in mid-run must drop every enable that software had set.
  task t_rerun;
    wr(OFF_IRQ_CONTROL, 32'hf8);
    wr(OFF_PERIPH_ENABLE_A, 32'hff);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFF_IRQ_CONTROL, 32'h0, "control after reset");
    rd(OFF_PERIPH_ENABLE_A, 32'h0, "enable a after reset");
  endtask

  // Main sequence: eight cycles of reset, then every scenario in turn.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pc_current = '0;
    return_from_irq = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_flags;
    t_group;
    t_stack;
    t_pin;
    t_rerun;
    close_out;
  end
endmodule
`default_nettype wire
